// ===== logic/oscc_ctrl.sv
// Optical sensor command controller: serial slave, register file and measurement sequencer
`timescale 1ns/1ps
`default_nettype none
`include "oscc_cfg.svh"

// Link timing: both link pins pass two flip-flops and an edge flop, so the
// slave sees every link clock edge about three clk cycles late. The master
// must keep the link clock low and high for at least four clk cycles each;
// faster bus modes only work while that still holds, which bounds the rate.
// Outgoing data changes on the detected falling edge, inside the low phase,
// and stands until the next detected falling edge.
//
// Register file: reads outside the window return zero, writes there are
// dropped. The identity byte and the two result pairs cannot be written,
// yet such writes are still acknowledged so the master sees no bus error.
// The pointer steps on after every data byte, written or read.
//
// Measurements: a start is a one-cycle pulse and the channel stays busy
// until the analog chain reports done. A done that arrives while idle is
// dropped, so a stray pulse cannot overwrite a result waiting to be read.
// While the sequencer runs, single-shot bits are not taken at all; mixing
// both ways of starting would make the busy bookkeeping ambiguous.
//
// Ready flags: reading either byte of a result clears its flag, but a new
// result in the same cycle wins, so fresh data is never reported as read.
// Interrupt: pulled low while any ready flag stands; no thresholds here.

module oscc_ctrl import oscc_pkg::*; #(
  parameter int unsigned SEQ_PERIOD_CYCLES = `OSCC_SEQ_PERIOD_CYCLES
) (
  // Clock and asynchronous reset
  input wire logic clk,
  input wire logic rst_n,
  // Link pins; the data output is an open-drain pull enable
  input wire logic scl_i,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe,
  output logic int_o,
  output logic int_oe,
  // Low-power oscillator enable and measurement handshake
  output logic osc_enable,
  output oscc_meas_req_t meas_req,
  input wire oscc_meas_res_t meas_res
);

  oscc_st_t st; // Registered state
  oscc_st_t next_st; // Next state
  logic scl_rise; // Clock edge toward high
  logic scl_fall; // Clock edge toward low
  logic start_cond; // Data falls while clock high
  logic stop_cond; // Data rises while clock high
  logic ptr_ok; // Pointer inside register window
  logic [4:0] idx; // Register index from pointer

  // Edges come from synchronised copies only; the first stage stays private
  assign scl_rise = st.scl_s2 & ~st.scl_p;
  assign scl_fall = ~st.scl_s2 & st.scl_p;
  assign start_cond = st.scl_s2 & st.scl_p & st.sda_p & ~st.sda_s2;
  assign stop_cond = st.scl_s2 & st.scl_p & ~st.sda_p & st.sda_s2;
  assign ptr_ok = (st.ptr >= `OSCC_REG_BASE) && (st.ptr <= `OSCC_REG_LAST); // RL4
  assign idx = 5'(st.ptr - `OSCC_REG_BASE);

  // Reset image of the state
  function automatic oscc_st_t reset_st();
    oscc_st_t r;
    r = '0;
    r.scl_s1 = 1'b1;
    r.scl_s2 = 1'b1;
    r.sda_s1 = 1'b1;
    r.sda_s2 = 1'b1;
    r.scl_p = 1'b1;
    r.sda_p = 1'b1;
    r.state = OSCC_IDLE;
    r.regs[`OSCC_IDX_CMD] = `OSCC_CMD_RESET;
    r.regs[`OSCC_IDX_ID] = `OSCC_ID_VALUE;
    return r;
  endfunction : reset_st

  // All next-state logic
  always_comb begin
    logic [7:0] rd_byte; // Byte fetched for the master
    logic [7:0] wr_byte; // Byte just received
    logic load; // Fetch a read byte this cycle
    logic clr_amb; // Ambient result was read
    logic clr_bio; // Bio result was read
    logic seq_tick; // Sequencer interval elapsed
    logic [7:0] cmd; // Command register working copy
    rd_byte = 8'h00;
    wr_byte = {st.shreg[6:0], st.sda_s2};
    load = 1'b0;
    clr_amb = 1'b0;
    clr_bio = 1'b0;
    seq_tick = 1'b0;
    cmd = st.regs[`OSCC_IDX_CMD];
    // Hold every field by default; requests last one cycle only
    next_st = st;
    next_st.req = '0;

    // Two-stage synchronisers, then previous-value copies for edges
    // Only the second stage feeds logic; the first may still be settling
    next_st.scl_s1 = scl_i;
    next_st.scl_s2 = st.scl_s1;
    next_st.sda_s1 = sda_i;
    next_st.sda_s2 = st.sda_s1;
    next_st.scl_p = st.scl_s2;
    next_st.sda_p = st.sda_s2;

    // Serial slave; sampling every clk edge bounds the usable link rate
    case (st.state) // RL2
      // Bus free or another slave addressed: data line released
      OSCC_IDLE: begin
        next_st.sda_oe = 1'b0;
      end
      // Seven address bits and the direction bit, taken on rising edges
      OSCC_ADDR: begin
        if (scl_rise) begin
          next_st.shreg = wr_byte;
          next_st.bitcnt = st.bitcnt + 4'h1;
        end else if (scl_fall && st.bitcnt == 4'h8) begin
          next_st.bitcnt = 4'h0;
          // Acknowledge only our own address; other traffic is ignored
          if (st.shreg[7:1] == `OSCC_SLAVE_ADDR) begin // RL3
            next_st.sda_oe = 1'b1;
            next_st.rw = st.shreg[0];
            next_st.first = ~st.shreg[0];
            next_st.state = OSCC_ACK;
          end else begin
            next_st.state = OSCC_IDLE; // Other slaves' traffic
          end
        end
      end
      OSCC_ACK: begin
        // Acknowledge held for one clock pulse; on its fall a write releases the line, a read drives the first data bit
        if (scl_fall) begin
          next_st.sda_oe = 1'b0;
          if (st.rw) begin
            load = 1'b1;
            next_st.state = OSCC_RD;
          end else begin
            next_st.state = OSCC_WR;
          end
        end
      end
      // First byte after the address loads the pointer, later ones are data
      OSCC_WR: begin
        if (scl_rise) begin
          next_st.shreg = wr_byte;
          next_st.bitcnt = st.bitcnt + 4'h1;
        end else if (scl_fall && st.bitcnt == 4'h8) begin
          next_st.bitcnt = 4'h0;
          next_st.sda_oe = 1'b1;
          next_st.state = OSCC_ACK;
          if (st.first) begin
            next_st.ptr = st.shreg; // RL16
            next_st.first = 1'b0;
          end else begin
            next_st.ptr = st.ptr + 8'h01;
          end
        end
      end
      // Fetched byte goes out most significant bit first
      OSCC_RD: begin
        if (scl_rise) begin
          next_st.bitcnt = st.bitcnt + 4'h1;
        end else if (scl_fall) begin
          // Eighth bit sent: the master owns the line for its acknowledge
          if (st.bitcnt == 4'h8) begin
            next_st.bitcnt = 4'h0;
            next_st.sda_oe = 1'b0;
            next_st.state = OSCC_RACK;
          end else begin
            // Next bit: pull low for a zero, release for a one
            next_st.shreg = {st.shreg[6:0], 1'b0};
            next_st.sda_oe = ~st.shreg[6]; // RL13
          end
        end
      end
      OSCC_RACK: begin
        // Master acknowledge asks for the next byte, no-acknowledge ends
        if (scl_rise) begin
          next_st.nack = st.sda_s2;
        end else if (scl_fall) begin
          if (st.nack) begin
            next_st.state = OSCC_IDLE;
          end else begin
            load = 1'b1;
            next_st.state = OSCC_RD;
          end
        end
      end
      // Unused state codes recover to idle
      default: begin
        next_st.state = OSCC_IDLE;
      end
    endcase

    // Read fetch: auto-increment, result reads clear the ready flags
    if (load) begin
      rd_byte = ptr_ok ? st.regs[idx] : 8'h00; // RL1
      next_st.shreg = rd_byte;
      next_st.sda_oe = ~rd_byte[7];
      next_st.ptr = st.ptr + 8'h01;
      // Either byte of a result clears its flag, in any order
      clr_amb = ptr_ok && (idx == `OSCC_IDX_AMB_HI || idx == `OSCC_IDX_AMB_LO); // RL6
      clr_bio = ptr_ok && (idx == `OSCC_IDX_BIO_HI || idx == `OSCC_IDX_BIO_LO); // RL7
    end

    // Start and stop win over any byte in progress
    // A repeated start restarts address collection without a stop
    if (start_cond) begin
      next_st.state = OSCC_ADDR;
      next_st.bitcnt = 4'h0;
      next_st.sda_oe = 1'b0;
    end else if (stop_cond) begin
      next_st.state = OSCC_IDLE;
      next_st.sda_oe = 1'b0;
    end

    // Register writes; results, identity and lock bit are read only
    if (st.state == OSCC_WR && scl_fall && st.bitcnt == 4'h8 && !st.first && ptr_ok) begin
      // Command byte: enables stored directly, starts only when allowed
      if (idx == `OSCC_IDX_CMD) begin
        cmd[2:0] = st.shreg[2:0]; // RL5 RL10 RL11
        if (!st.shreg[`OSCC_CMD_SEQ_EN] && !st.regs[`OSCC_IDX_CMD][`OSCC_CMD_SEQ_EN]) begin
          cmd[`OSCC_CMD_AMB_SS] = cmd[`OSCC_CMD_AMB_SS] | st.shreg[`OSCC_CMD_AMB_SS]; // RL9
          cmd[`OSCC_CMD_BIO_SS] = cmd[`OSCC_CMD_BIO_SS] | st.shreg[`OSCC_CMD_BIO_SS]; // RL8
        end // RL14
      end else if (idx != `OSCC_IDX_ID && (idx < `OSCC_IDX_AMB_HI || idx > `OSCC_IDX_BIO_LO)) begin
        next_st.regs[idx] = st.shreg; // RL1
      end
    end

    // Self-timed sequencer on a divided interval while enabled
    // The counter restarts whenever the sequencer is off, so the first
    // tick comes one full interval after it is switched on
    next_st.osc_en = cmd[`OSCC_CMD_SEQ_EN]; // RL12
    if (!cmd[`OSCC_CMD_SEQ_EN]) begin
      next_st.seq_cnt = '0;
    end else if (st.seq_cnt >= 32'(SEQ_PERIOD_CYCLES - 1)) begin
      next_st.seq_cnt = '0;
      seq_tick = 1'b1;
    end else begin
      next_st.seq_cnt = st.seq_cnt + 32'h1;
    end

    // Start requests: periodic under sequencer, otherwise on demand
    if (!st.amb_busy && ((seq_tick && cmd[`OSCC_CMD_AMB_PER]) || // RL10 RL12
        (!cmd[`OSCC_CMD_SEQ_EN] && cmd[`OSCC_CMD_AMB_SS]))) begin // RL9
      next_st.amb_busy = 1'b1;
      next_st.req.amb_start = 1'b1;
    end
    if (!st.bio_busy && ((seq_tick && cmd[`OSCC_CMD_BIO_PER]) || // RL11 RL12
        (!cmd[`OSCC_CMD_SEQ_EN] && cmd[`OSCC_CMD_BIO_SS]))) begin // RL8
      next_st.bio_busy = 1'b1;
      next_st.req.bio_start = 1'b1;
    end

    // Ready flags: clear on result read, but a new result wins
    if (clr_amb) begin
      cmd[`OSCC_CMD_AMB_RDY] = 1'b0; // RL6
    end
    if (clr_bio) begin
      cmd[`OSCC_CMD_BIO_RDY] = 1'b0; // RL7
    end
    // A done while idle is dropped; done also retires the single-shot bit
    if (meas_res.amb_done && st.amb_busy) begin
      next_st.amb_busy = 1'b0;
      next_st.regs[`OSCC_IDX_AMB_HI] = meas_res.amb_value[15:8]; // RL9
      next_st.regs[`OSCC_IDX_AMB_LO] = meas_res.amb_value[7:0];
      cmd[`OSCC_CMD_AMB_RDY] = 1'b1; // RL6
      cmd[`OSCC_CMD_AMB_SS] = 1'b0;
    end
    if (meas_res.bio_done && st.bio_busy) begin
      next_st.bio_busy = 1'b0;
      next_st.regs[`OSCC_IDX_BIO_HI] = meas_res.bio_value[15:8]; // RL8
      next_st.regs[`OSCC_IDX_BIO_LO] = meas_res.bio_value[7:0];
      cmd[`OSCC_CMD_BIO_RDY] = 1'b1; // RL7
      cmd[`OSCC_CMD_BIO_SS] = 1'b0;
    end
    cmd[`OSCC_CMD_LOCK] = 1'b1;
    next_st.regs[`OSCC_IDX_CMD] = cmd; // RL5

    // Interrupt pulled low while any result waits to be read
    next_st.int_oe = cmd[`OSCC_CMD_AMB_RDY] | cmd[`OSCC_CMD_BIO_RDY]; // RL13
  end

  // State register
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      // Link lines reset idle-high, so no false start follows reset
      st <= reset_st();
    end else begin
      st <= next_st;
    end
  end

  // Outputs straight from state; open-drain pins only ever drive low
  assign sda_o = 1'b0; // RL13
  assign sda_oe = st.sda_oe;
  assign int_o = 1'b0; // RL13
  assign int_oe = st.int_oe;
  // Oscillator enable and one-cycle start pulses
  assign osc_enable = st.osc_en;
  assign meas_req = st.req;

endmodule : oscc_ctrl
`default_nettype wire

// ===== logic/oscc_cfg.svh
// Constants of the optical sensor command controller: offsets, fields, resets, timing
//
// Summary of operation
// RL1: Seventeen 8-bit registers, all reached over serial link
// RL2: Slave works in standard, fast, high-speed modes; link clock needs 4 clk low and 4 clk high (400 ns period at 20 MHz)
// RL3: Answers only slave address 13h (26h/27h)
// RL4: Register addresses run 80h to 90h, master stays inside
// RL5: Command register 80h starts measurements, holds ready flags
// RL6: Ambient ready set on result, cleared reading 85h/86h
// RL7: Bio ready set on result, cleared reading 87h/88h
// RL8: Bio single shot fills 87h high, 88h low
// RL9: Ambient single shot fills 85h high, 86h low
// RL10: Ambient periodic enable repeats ambient under sequencer
// RL11: Bio periodic enable repeats bio under sequencer
// RL12: Sequencer enable starts oscillator; channel enable gates measurements
// RL13: Interrupt output is open drain, only pulls low
// RL14: Single-shot starts ignored while sequencer enabled
// RL15: Master changes rates only with sequencer off
// RL16: Access: address, register byte, data or restart-read
`ifndef OSCC_CFG_SVH
`define OSCC_CFG_SVH

// Link addressing
`define OSCC_SLAVE_ADDR 7'h13
`define OSCC_REG_BASE 8'h80
`define OSCC_REG_LAST 8'h90
`define OSCC_REG_COUNT 17

// Register indices (offset minus base)
`define OSCC_IDX_CMD 5'h00
`define OSCC_IDX_ID 5'h01
`define OSCC_IDX_AMB_HI 5'h05
`define OSCC_IDX_AMB_LO 5'h06
`define OSCC_IDX_BIO_HI 5'h07
`define OSCC_IDX_BIO_LO 5'h08

// Command register fields
`define OSCC_CMD_LOCK 7
`define OSCC_CMD_AMB_RDY 6
`define OSCC_CMD_BIO_RDY 5
`define OSCC_CMD_AMB_SS 4
`define OSCC_CMD_BIO_SS 3
`define OSCC_CMD_AMB_PER 2
`define OSCC_CMD_BIO_PER 1
`define OSCC_CMD_SEQ_EN 0

// Reset values; identity value is arbitrary
`define OSCC_CMD_RESET 8'h80
`define OSCC_ID_VALUE 8'h5a
`define OSCC_REG_RESET 8'h00

// Sequencer interval
`define OSCC_CLK_MHZ 20
`define OSCC_SEQ_PERIOD_US 1000
`define OSCC_SEQ_PERIOD_CYCLES (`OSCC_SEQ_PERIOD_US * `OSCC_CLK_MHZ)

`endif

// ===== logic/oscc_pkg.sv
// Types of the optical sensor command controller
package oscc_pkg;

  // Serial slave states
  typedef enum logic [2:0] {
    OSCC_IDLE = 3'b000,
    OSCC_ADDR = 3'b001,
    OSCC_ACK = 3'b010,
    OSCC_WR = 3'b011,
    OSCC_RD = 3'b100,
    OSCC_RACK = 3'b101
  } oscc_state_t;

  // Measurement start requests towards the analog chain
  typedef struct packed {
    logic amb_start;
    logic bio_start;
  } oscc_meas_req_t;

  // Finished measurements from the analog chain
  typedef struct packed {
    logic amb_done;
    logic [15:0] amb_value;
    logic bio_done;
    logic [15:0] bio_value;
  } oscc_meas_res_t;

  // Whole state of the controller
  typedef struct packed {
    logic scl_s1;
    logic scl_s2;
    logic sda_s1;
    logic sda_s2;
    logic scl_p;
    logic sda_p;
    oscc_state_t state;
    logic [3:0] bitcnt;
    logic [7:0] shreg;
    logic rw;
    logic first;
    logic nack;
    logic [7:0] ptr;
    logic sda_oe;
    logic [16:0][7:0] regs;
    logic amb_busy;
    logic bio_busy;
    logic [31:0] seq_cnt;
    logic osc_en;
    oscc_meas_req_t req;
    logic int_oe;
  } oscc_st_t;

endpackage : oscc_pkg

// ===== tb/oscc_ctrl_checker.sv
// Port assertions of the optical sensor command controller
`timescale 1ns/1ps
`default_nettype none
module oscc_ctrl_checker import oscc_pkg::*; (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic scl_i,
  input wire logic sda_o,
  input wire logic sda_oe,
  input wire logic int_o,
  input wire logic int_oe,
  input wire oscc_meas_req_t meas_req,
  input wire oscc_meas_res_t meas_res
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);
  // Start pulse answered by a result in the same or the next sampled cycle
  sequence s_amb_end;
    meas_req.amb_start ##[0:1] meas_res.amb_done;
  endsequence
  sequence s_bio_end;
    meas_req.bio_start ##[0:1] meas_res.bio_done;
  endsequence
  // Pins may only pull low, never drive high
  AST_OPEN_DRAIN: assert property (sda_o == 1'b0 && int_o == 1'b0)
    else $error("open-drain pin driven high");
  AST_AMB_INT: assert property (s_amb_end |-> ##[1:3] int_oe)
    else $error("ambient result without interrupt");
  AST_BIO_INT: assert property (s_bio_end |-> ##[1:3] int_oe)
    else $error("bio result without interrupt");
  AST_INT_CAUSE: assert property ($rose(int_oe) |-> $past(meas_res.amb_done) || $past(meas_res.bio_done))
    else $error("interrupt without a result");
  AST_AMB_PULSE: assert property (meas_req.amb_start |=> !meas_req.amb_start)
    else $error("ambient start longer than one cycle");
  AST_BIO_PULSE: assert property (meas_req.bio_start |=> !meas_req.bio_start)
    else $error("bio start longer than one cycle");
  // Data may only change after the link clock went low
  AST_SDA_EDGE: assert property ($changed(sda_oe) |-> !$past(scl_i))
    else $error("data changed while link clock high");
  AST_SDA_HOLD: assert property ($rose(sda_oe) |=> sda_oe [*3])
    else $error("data pull released too early");
endmodule : oscc_ctrl_checker
bind oscc_ctrl oscc_ctrl_checker i_oscc_ctrl_checker (.clk(clk), .rst_n(rst_n), .scl_i(scl_i),
  .sda_o(sda_o), .sda_oe(sda_oe), .int_o(int_o), .int_oe(int_oe), .meas_req(meas_req), .meas_res(meas_res));
`default_nettype wire

// ===== tb/oscc_host_model.sv
// Host stand-in: bit-level link master with open-drain data
`timescale 1ns/1ps
`default_nettype none
module oscc_host_model (
  input wire logic clk,
  input wire logic sda,
  output var logic scl,
  output var logic sda_low,
  output var logic stb,
  output var logic [8:0] rx
);
  // Link clock idles high and stands still between frames
  initial begin
    scl = 1'b1;
    sda_low = 1'b0;
    stb = 1'b0;
  end
  // Lines change only at falling clock edges
  task automatic tk(input int n);
    repeat (n) @(negedge clk);
  endtask : tk
  // Start (st=1) or stop (st=0); a start over a held line goes through a low clock
  task automatic cond(input logic st);
    if (!st || !sda) begin
      scl = 1'b0;
      tk(1);
      sda_low = !st;
      tk(4);
      scl = 1'b1;
      tk(4);
    end
    sda_low = st;
    tk(4);
  endtask : cond
  // Nine bits, low 4 clk and high 4 clk: a 400 ns link clock, the slave's limit
  task automatic xfer(input logic [8:0] tx);
    for (int i = 8; i >= 0; i--) begin
      scl = 1'b0;
      tk(1);
      sda_low = !tx[i];
      tk(3);
      scl = 1'b1;
      tk(2);
      rx[i] = sda;
      tk(2);
    end
    stb = 1'b1;
    tk(1);
    stb = 1'b0;
  endtask : xfer
endmodule : oscc_host_model
`default_nettype wire

// ===== tb/optical_sensor_command_ctrl_tb.sv
// Self-checking bench of the optical sensor command controller
`timescale 1ns/1ps
`default_nettype none
module optical_sensor_command_ctrl_tb;
  import oscc_pkg::*;
  localparam int SEQ = 50; // Short sequencer interval keeps the run brief
  logic clk, rst_n, sda_o, sda_oe, int_o, int_oe, osc_en, scl, p_low, stb;
  logic [8:0] rx;
  logic [8:0] q[$]; // Expected bytes with their acknowledge bit
  logic [15:0] va, vb;
  logic [7:0] d;
  logic [7:0] rw[5] = '{8'h82, 8'h83, 8'h84, 8'h89, 8'h90};
  oscc_meas_req_t req;
  oscc_meas_res_t res;
  int fails = 0, n_compared = 0, seed = 82190, n_amb = 0, n_bio = 0, b, c;
  wire logic sda_line = !(p_low | (sda_oe & !sda_o)); // Pull-up wins unless a party pulls low
  wire logic int_line = !(int_oe & !int_o); // Interrupt line with its pull-up
  oscc_ctrl #(.SEQ_PERIOD_CYCLES(SEQ)) i_oscc_ctrl (.clk(clk), .rst_n(rst_n), .scl_i(scl), .sda_i(sda_line),
    .sda_o(sda_o), .sda_oe(sda_oe), .int_o(int_o), .int_oe(int_oe), .osc_enable(osc_en), .meas_req(req),
    .meas_res(res));
  oscc_host_model i_oscc_host_model (.clk(clk), .sda(sda_line), .scl(scl), .sda_low(p_low), .stb(stb), .rx(rx));
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  // Analog chain stand-in: answers each start a cycle later and counts starts
  always @(negedge clk) begin
    res <= '{req.amb_start, va, req.bio_start, vb};
    n_amb <= n_amb + int'(req.amb_start);
    n_bio <= n_bio + int'(req.bio_start);
  end
  task automatic cmp(input string s, input logic [8:0] ex, input logic [8:0] got);
    n_compared++;
    if (got !== ex) begin
      $display("[ERR] %s expected %h seen %h", s, ex, got);
      fails++;
    end
  endtask : cmp
  // Each finished byte is matched with the oldest note
  always @(posedge stb) cmp("link byte", q.pop_front(), rx);
  task automatic xb(input logic [8:0] tx, input logic [8:0] ex);
    q.push_back(ex);
    i_oscc_host_model.xfer(tx);
  endtask : xb
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    i_oscc_host_model.cond(1'b1);
    xb(9'h04d, 9'h04c);
    xb({a, 1'b1}, {a, 1'b0});
    xb({v, 1'b1}, {v, 1'b0});
    i_oscc_host_model.cond(1'b0);
  endtask : wr
  // Register pointer write, repeated start, one byte read and refused
  task automatic rd(input logic [7:0] a, input logic [7:0] ex);
    i_oscc_host_model.cond(1'b1);
    xb(9'h04d, 9'h04c);
    xb({a, 1'b1}, {a, 1'b0});
    i_oscc_host_model.cond(1'b1);
    xb(9'h04f, 9'h04e);
    xb(9'h1ff, {ex, 1'b1});
    i_oscc_host_model.cond(1'b0);
  endtask : rd
  task automatic give_verdict();
    $display("compared %0d mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : give_verdict
  // Hang guard
  initial begin
    repeat (100000) @(posedge clk);
    fails++;
    give_verdict();
  end
  initial begin
    rst_n = 1'b0;
    va = 16'($random(seed));
    vb = 16'($random(seed));
    repeat (12) @(negedge clk);
    rst_n = 1'b1;
    repeat (4) @(negedge clk);
    rd(8'h80, 8'h80);
    i_oscc_host_model.cond(1'b1);
    xb(9'h051, 9'h051);
    i_oscc_host_model.cond(1'b0);
    foreach (rw[i]) begin
      d = 8'($random(seed));
      wr(rw[i], d);
      rd(rw[i], d);
    end
    wr(8'h80, 8'h10);
    rd(8'h80, 8'hc0);
    cmp("int line", 9'h000, {8'h00, int_line});
    rd(8'h85, va[15:8]);
    rd(8'h80, 8'h80);
    rd(8'h86, va[7:0]);
    cmp("int line", 9'h001, {8'h00, int_line});
    wr(8'h80, 8'h08);
    rd(8'h80, 8'ha0);
    rd(8'h88, vb[7:0]);
    rd(8'h80, 8'h80);
    rd(8'h87, vb[15:8]);
    b = n_amb;
    c = n_bio;
    wr(8'h80, 8'h01);
    wr(8'h80, 8'h19);
    cmp("osc_enable", 9'h001, {8'h00, osc_en});
    repeat (3 * SEQ) @(negedge clk);
    cmp("start count", 9'h000, 9'(n_amb + n_bio - b - c));
    rd(8'h80, 8'h81);
    wr(8'h80, 8'h07);
    repeat (3 * SEQ) @(negedge clk);
    cmp("amb repeats", 9'h001, {8'h00, n_amb >= b + 2});
    cmp("bio repeats", 9'h001, {8'h00, n_bio >= c + 2});
    wr(8'h80, 8'h00);
    cmp("osc_enable", 9'h000, {8'h00, osc_en});
    give_verdict();
  end
endmodule : optical_sensor_command_ctrl_tb
`default_nettype wire
